// ---- design/rx_decode_framer_select.sv ----
// receive decoder mode and character framer selection for one channel
`timescale 1ns/1ps
// Behaviour
// RL1 - decoder bypassed: raw 10-bit character delivered
// RL2 - bypass requires clock source select at middle
// RL3 - middle: decoder on, primary special table
// RL4 - high: decoder on, alternate special table
// RL5 - framer uses framing character, bonding mode
// RL6 - low: low-latency framer, realign every match
// RL7 - low-latency realign stretches character clock; code restarts the count at the match, cutting the current character short
// RL8 - middle: two matches, same boundary, 50 bits
// RL9 - high: four consecutive matches, same boundary
// RL10 - multi-byte framers keep character clock phase
// RL11 - selections static three-level, never toggled
// RL12 - source middle: clock out follows own rate
// RL13 - selections captured to stable two-bit codes
module rx_decode_framer_select
	import rx_framer_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       serial_bit_in,
	input  wire logic       serial_bit_toggle,
	input  wire logic [1:0] decoder_mode_select,
	input  wire logic [1:0] reframe_mode_select,
	input  wire logic [1:0] rx_clock_source_select,
	input  wire logic       rx_clock_rate_select,
	input  wire logic       framing_full_k,
	input  wire logic [1:0] bonding_mode,
	input  wire logic       rx_out_ready,
	output logic            rx_out_valid_q,
	output logic [9:0]      rx_char_q,
	output logic [2:0]      rx_status_q,
	output logic            rx_overrun_q,
	output logic            recovered_clock_out_q
);
	logic [SYNC_BITS-1:0]  sync1_q;
	logic [SYNC_BITS-1:0]  sync2_q;
	logic                  tog3_q;
	logic [3:0]            settle_q;
	logic                  cfg_done_q;
	level_e                dec_code_q;
	level_e                rf_code_q;
	level_e                src_code_q;
	logic                  rate_q;
	logic                  full_k_q;
	logic                  bonded_q;
	logic [SHIFT_BITS-1:0] sh_q;
	logic [SHIFT_BITS-1:0] sh_d;
	logic [3:0]            cnt_q;
	logic [3:0]            off_q;
	logic [3:0]            ref_off_q;
	logic [5:0]            span_q;
	logic [1:0]            hits_q;
	logic                  bit_arrive;
	logic                  match;
	logic                  ll_mode;
	logic                  ll_match;
	logic [3:0]            match_off;
	logic                  emit;
	logic [9:0]            emit_char;
	logic [5:0]            d6;
	logic [4:0]            d4;
	logic [2:0]            push_status;
	logic [9:0]            push_char;
	logic                  buf_ready_q;

	function automatic level_e level_of(input logic [1:0] pins);
		level_of = (pins == 2'b00) ? LVL_LOW : (pins == 2'b11) ? LVL_HIGH : LVL_MID;
	endfunction

	function automatic logic [5:0] dec6(input logic [5:0] c);
		dec6 = 6'h00;
		unique case (c)
			6'h27, 6'h18: dec6 = 6'h20;
			6'h1d, 6'h22: dec6 = 6'h21;
			6'h2d, 6'h12: dec6 = 6'h22;
			6'h31:        dec6 = 6'h23;
			6'h35, 6'h0a: dec6 = 6'h24;
			6'h29:        dec6 = 6'h25;
			6'h19:        dec6 = 6'h26;
			6'h38, 6'h07: dec6 = 6'h27;
			6'h39, 6'h06: dec6 = 6'h28;
			6'h25:        dec6 = 6'h29;
			6'h15:        dec6 = 6'h2a;
			6'h34:        dec6 = 6'h2b;
			6'h0d:        dec6 = 6'h2c;
			6'h2c:        dec6 = 6'h2d;
			6'h1c:        dec6 = 6'h2e;
			6'h17, 6'h28: dec6 = 6'h2f;
			6'h1b, 6'h24: dec6 = 6'h30;
			6'h23:        dec6 = 6'h31;
			6'h13:        dec6 = 6'h32;
			6'h32:        dec6 = 6'h33;
			6'h0b:        dec6 = 6'h34;
			6'h2a:        dec6 = 6'h35;
			6'h1a:        dec6 = 6'h36;
			6'h3a, 6'h05: dec6 = 6'h37;
			6'h33, 6'h0c: dec6 = 6'h38;
			6'h26:        dec6 = 6'h39;
			6'h16:        dec6 = 6'h3a;
			6'h36, 6'h09: dec6 = 6'h3b;
			6'h0e, 6'h0f, 6'h30: dec6 = 6'h3c;
			6'h2e, 6'h11: dec6 = 6'h3d;
			6'h1e, 6'h21: dec6 = 6'h3e;
			6'h2b, 6'h14: dec6 = 6'h3f;
			default:      dec6 = 6'h00;
		endcase
	endfunction

	function automatic logic [4:0] dec4(input logic [3:0] c);
		dec4 = 5'h00;
		unique case (c)
			4'hb, 4'h4: dec4 = 5'h08;
			4'h9:       dec4 = 5'h09;
			4'h5:       dec4 = 5'h0a;
			4'hc, 4'h3: dec4 = 5'h0b;
			4'hd, 4'h2: dec4 = 5'h0c;
			4'ha:       dec4 = 5'h0d;
			4'h6:       dec4 = 5'h0e;
			4'he, 4'h1: dec4 = 5'h0f;
			4'h7, 4'h8: dec4 = 5'h1f;
			default:    dec4 = 5'h00;
		endcase
	endfunction

	// pins pass two flops; the second stage feeds logic, and a third flop on the toggle (tog3_q) feeds the edge detect
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			tog3_q  <= 1'b0;
		end else begin
			sync1_q <= {serial_bit_in, serial_bit_toggle, decoder_mode_select, reframe_mode_select,
				rx_clock_source_select, rx_clock_rate_select, framing_full_k, bonding_mode};
			sync2_q <= sync1_q;
			tog3_q  <= sync2_q[10];
		end
	end

	// settings sampled once after reset and then held
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settle_q   <= '0;
			cfg_done_q <= 1'b0;
			dec_code_q <= LVL_LOW;
			rf_code_q  <= LVL_LOW;
			src_code_q <= LVL_LOW;
			rate_q     <= 1'b0;
			full_k_q   <= 1'b0;
			bonded_q   <= 1'b0;
		end else if (!cfg_done_q) begin
			settle_q <= settle_q + 4'h1;
			if (settle_q == CFG_SETTLE_CYCLES) begin
				cfg_done_q <= 1'b1; // RL11
				dec_code_q <= level_of(sync2_q[9:8]); // RL13
				rf_code_q  <= level_of(sync2_q[7:6]); // RL13
				src_code_q <= level_of(sync2_q[5:4]); // RL13
				rate_q     <= sync2_q[3];
				full_k_q   <= sync2_q[2];
				bonded_q   <= |sync2_q[1:0];
			end
		end
	end

	assign bit_arrive = cfg_done_q & (sync2_q[10] ^ tog3_q);
	assign sh_d       = {sh_q[SHIFT_BITS-2:0], sync2_q[11]};
	// framing character: full pattern or comma prefix, either disparity
	assign match      = full_k_q ? (sh_d[9:0] == FRAME_FULL_NEG || sh_d[9:0] == FRAME_FULL_POS)
		: (sh_d[9:3] == FRAME_COMMA_NEG || sh_d[9:3] == FRAME_COMMA_POS); // RL5
	// bonded lanes must keep clock phase, so they never use the low-latency framer
	assign ll_mode    = (rf_code_q == LVL_LOW) && !bonded_q; // RL5
	assign ll_match   = bit_arrive & match & ll_mode; // RL6
	assign match_off  = CHAR_LAST - cnt_q;
	assign emit       = bit_arrive & ((cnt_q == CHAR_LAST) | ll_match);
	assign emit_char  = ll_match ? sh_d[9:0] : sh_d[off_q +: CHAR_BITS];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_q  <= '0;
			cnt_q <= '0;
		end else if (bit_arrive) begin
			sh_q <= sh_d;
			if (ll_match || cnt_q == CHAR_LAST) begin
				cnt_q <= '0; // RL7
			end else begin
				cnt_q <= cnt_q + 4'h1; // RL10
			end
		end
	end

	// boundary search for the multi-byte framers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			off_q     <= '0;
			ref_off_q <= '0;
			span_q    <= '0;
			hits_q    <= '0;
		end else if (ll_match) begin
			off_q  <= '0; // RL6
			hits_q <= '0;
		end else if (bit_arrive && match && !ll_mode) begin
			if (rf_code_q == LVL_HIGH && hits_q != 2'h0 && match_off == ref_off_q && span_q == CONSEC_SPAN) begin
				span_q <= '0;
				hits_q <= (hits_q == CONSEC_HITS_LAST) ? 2'h0 : hits_q + 2'h1;
				if (hits_q == CONSEC_HITS_LAST) begin
					off_q <= match_off; // RL9
				end
			end else if (rf_code_q != LVL_HIGH && hits_q != 2'h0 && match_off == ref_off_q
				&& span_q < PAIR_SPAN_MAX) begin
				off_q  <= match_off; // RL8
				hits_q <= '0;
			end else begin
				ref_off_q <= match_off;
				span_q    <= '0;
				hits_q    <= 2'h1;
			end
		end else if (bit_arrive) begin
			span_q <= (span_q == SPAN_SAT) ? span_q : span_q + 6'h1;
			if (span_q >= ((rf_code_q == LVL_HIGH) ? CONSEC_SPAN : PAIR_SPAN_MAX)) begin
				hits_q <= '0;
			end
		end
	end

	// decoder path: bypass, primary or alternate special table
	assign d6 = dec6(emit_char[9:4]);
	assign d4 = dec4(emit_char[3:0]);

	always_comb begin
		push_char   = emit_char; // RL1
		push_status = ST_DATA;
		if (dec_code_q != LVL_LOW) begin
			push_char = {2'b00, d4[2:0], d6[4:0]};
			if (!d6[5] || !d4[3]) begin
				push_status = ST_ERROR;
			end else if (emit_char[9:4] == 6'h0f || emit_char[9:4] == 6'h30 || (d4[4]
				&& !(d6[4:0] == 5'h11 || d6[4:0] == 5'h12 || d6[4:0] == 5'h14))) begin
				push_status = (dec_code_q == LVL_HIGH) ? ST_SPECIAL_ALT : ST_SPECIAL; // RL3 RL4
				if (emit_char[9:4] == 6'h0f || emit_char[9:4] == 6'h30) begin
					push_char[4:0] = K28_INDEX;
				end
			end
		end
	end

	char_skid_buffer #(
		.WIDTH (WORD_BITS)
	) u_buf (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.in_valid    (emit),
		.in_data     ({push_status, push_char}),
		.in_ready_q  (buf_ready_q),
		.out_valid_q (rx_out_valid_q),
		.out_data_q  ({rx_status_q, rx_char_q}),
		.out_ready   (rx_out_ready)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_overrun_q <= 1'b0;
		end else begin
			rx_overrun_q <= emit & ~buf_ready_q;
		end
	end

	// character clock out: character rate or half of it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			recovered_clock_out_q <= 1'b0;
		end else if (src_code_q != LVL_MID) begin
			recovered_clock_out_q <= 1'b0; // RL2
		end else if (emit) begin
			recovered_clock_out_q <= rate_q ? ~recovered_clock_out_q : 1'b1; // RL12
		end else if (bit_arrive && !rate_q && cnt_q == CLK_FALL_CNT) begin
			recovered_clock_out_q <= 1'b0; // RL12
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_ll_hit;
		ll_match && emit;
	endsequence
	sequence s_phase_reset;
		cnt_q == 4'h0;
	endsequence

	property p_bypass_raw;
		emit && dec_code_q == LVL_LOW |-> push_char == emit_char && push_status == ST_DATA;
	endproperty
	a_bypass_raw: assert property (p_bypass_raw) else $error("bypass altered the character"); // RL1

	property p_primary_table;
		emit && dec_code_q == LVL_MID |-> push_status != ST_SPECIAL_ALT;
	endproperty
	a_primary_table: assert property (p_primary_table) else $error("alternate code in primary mode"); // RL3

	property p_alt_table;
		emit && dec_code_q == LVL_HIGH |-> push_status != ST_SPECIAL;
	endproperty
	a_alt_table: assert property (p_alt_table) else $error("primary code in alternate mode"); // RL4

	property p_ll_realign;
		bit_arrive && match && ll_mode |-> s_ll_hit ##1 s_phase_reset ##1 off_q == 4'h0;
	endproperty
	a_ll_realign: assert property (p_ll_realign) else $error("low-latency realign missed"); // RL6 RL7

	property p_pair_window;
		rf_code_q == LVL_MID && $changed(off_q) |-> $past(hits_q) == 2'h1 && $past(span_q) < PAIR_SPAN_MAX;
	endproperty
	a_pair_window: assert property (p_pair_window) else $error("realign without a pair"); // RL8

	property p_four_run;
		rf_code_q == LVL_HIGH && $changed(off_q) |-> $past(hits_q) == CONSEC_HITS_LAST;
	endproperty
	a_four_run: assert property (p_four_run) else $error("realign before four in a row"); // RL9

	property p_phase_kept;
		bit_arrive && !ll_mode && cnt_q != CHAR_LAST |=> cnt_q == $past(cnt_q) + 4'h1;
	endproperty
	a_phase_kept: assert property (p_phase_kept) else $error("character phase moved"); // RL10

	property p_clock_follow;
		emit && src_code_q == LVL_MID && !rate_q |=> recovered_clock_out_q;
	endproperty
	a_clock_follow: assert property (p_clock_follow) else $error("clock out did not follow"); // RL12

	property p_codes_held;
		cfg_done_q |=> $stable(dec_code_q) && $stable(rf_code_q) && $stable(src_code_q);
	endproperty
	a_codes_held: assert property (p_codes_held) else $error("setting code changed"); // RL13
endmodule

// ---- design/rx_framer_pkg.sv ----
// shared constants and types for the receive decoder and framer selection block
package rx_framer_pkg;
	localparam int unsigned CHAR_BITS          = 10;
	localparam int unsigned SHIFT_BITS         = 2 * CHAR_BITS;
	localparam int unsigned MULTI_WINDOW_BITS  = 50;
	localparam int unsigned CONSEC_CHARS       = 4;
	localparam logic [3:0]  CHAR_LAST          = 4'h9;
	localparam logic [3:0]  CLK_FALL_CNT       = 4'h4;
	localparam logic [5:0]  PAIR_SPAN_MAX      = 6'(MULTI_WINDOW_BITS - CHAR_BITS);
	localparam logic [5:0]  CONSEC_SPAN        = 6'(CHAR_BITS - 1);
	localparam logic [5:0]  SPAN_SAT           = 6'h3f;
	localparam logic [1:0]  CONSEC_HITS_LAST   = 2'(CONSEC_CHARS - 1);
	localparam logic [3:0]  CFG_SETTLE_CYCLES  = 4'h8;
	localparam logic [9:0]  FRAME_FULL_NEG     = 10'h0fa;
	localparam logic [9:0]  FRAME_FULL_POS     = 10'h305;
	localparam logic [6:0]  FRAME_COMMA_NEG    = 7'h1f;
	localparam logic [6:0]  FRAME_COMMA_POS    = 7'h60;
	localparam logic [4:0]  K28_INDEX          = 5'h1c;
	localparam logic [2:0]  ST_DATA            = 3'h0;
	localparam logic [2:0]  ST_SPECIAL         = 3'h1;
	localparam logic [2:0]  ST_SPECIAL_ALT     = 3'h2;
	localparam logic [2:0]  ST_ERROR           = 3'h7;
	localparam int unsigned WORD_BITS          = 3 + CHAR_BITS;
	localparam int unsigned SYNC_BITS          = 12;

	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_e;
endpackage

// ---- design/char_skid_buffer.sv ----
// two-entry buffer with valid and ready on both sides, all outputs registered
`timescale 1ns/1ps
module char_skid_buffer #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready_q,
	output logic                  out_valid_q,
	output logic      [WIDTH-1:0] out_data_q,
	input  wire logic             out_ready
);
	logic             skid_valid_q;
	logic [WIDTH-1:0] skid_q;
	logic             push;
	logic             main_free;

	assign push      = in_valid & in_ready_q;
	assign main_free = ~out_valid_q | out_ready;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else if (main_free) begin
			if (skid_valid_q) begin
				out_valid_q <= 1'b1;
				out_data_q  <= skid_q;
			end else begin
				out_valid_q <= push;
				if (push) begin
					out_data_q <= in_data;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			skid_valid_q <= 1'b0;
			skid_q       <= '0;
			in_ready_q   <= 1'b1;
		end else if (push && !main_free) begin
			skid_valid_q <= 1'b1;
			skid_q       <= in_data;
			in_ready_q   <= 1'b0;
		end else if (skid_valid_q && main_free) begin
			skid_valid_q <= 1'b0;
			in_ready_q   <= 1'b1;
		end
	end
endmodule

// ---- verification/serial_tx_model.sv ----
// remote serial transmitter model: one bit per toggle change, top bit first
`timescale 1ns/1ps
module serial_tx_model #(
	parameter int unsigned BIT_GAP = 5
) (
	input  wire logic        clk_sys,
	input  wire logic        tx_start,
	input  wire logic [63:0] tx_bits,
	input  wire logic [6:0]  tx_count,
	output logic             tx_busy,
	output logic             serial_bit_in,
	output logic             serial_bit_toggle
);
	int left;
	int gap;
	initial begin
		tx_busy = 1'b0;
		serial_bit_in = 1'b0;
		serial_bit_toggle = 1'b0;
		left = 0;
		gap = 0;
	end
	always @(negedge clk_sys) begin
		if (tx_start && !tx_busy) begin
			tx_busy = 1'b1;
			left = int'(tx_count);
			gap = 0;
		end
		if (tx_busy && gap > 0) begin
			gap--;
		end else if (tx_busy && left == 0) begin
			tx_busy = 1'b0;
			serial_bit_in = ~serial_bit_in; // hold time over, data no longer meaningful
		end else if (tx_busy) begin
			serial_bit_in = tx_bits[left-1];
			serial_bit_toggle = ~serial_bit_toggle;
			left--;
			gap = BIT_GAP - 1;
		end
	end
endmodule

// ---- verification/rx_decode_framer_select_bench.sv ----
// self-checking bench for the receive decoder and framer selection block
`timescale 1ns/1ps
module rx_decode_framer_select_bench;
	import rx_framer_pkg::*;
	typedef struct packed {
		logic [1:0] dec;
		logic [1:0] rf;
		logic       fk;
		logic [9:0] data;
		logic [9:0] e0;
		logic [2:0] s0;
		logic [9:0] e1;
		logic [2:0] s1;
	} row_s;
	localparam logic [9:0] K_CH = 10'h0fa;
	localparam logic [9:0] D_A  = 10'h2aa;
	localparam logic [9:0] D_B  = 10'h155;
	row_s rows [6] = '{
		'{2'b00, 2'b00, 1'b1, D_A, K_CH, 3'h0, D_A, 3'h0},
		'{2'b01, 2'b01, 1'b1, D_A, 10'h0bc, 3'h1, 10'h0b5, 3'h0},
		'{2'b11, 2'b11, 1'b1, D_A, 10'h0bc, 3'h2, 10'h0b5, 3'h0},
		'{2'b10, 2'b00, 1'b0, D_B, 10'h0bc, 3'h1, 10'h04a, 3'h0},
		'{2'b11, 2'b10, 1'b0, D_B, 10'h0bc, 3'h2, 10'h04a, 3'h0},
		'{2'b11, 2'b00, 1'b1, 10'h2a8, 10'h0bc, 3'h2, 10'h0f5, 3'h2}
	};
	logic       clk_sys;
	logic       rst_n;
	logic [1:0] decoder_mode_select;
	logic [1:0] reframe_mode_select;
	logic [1:0] rx_clock_source_select;
	logic       rx_clock_rate_select;
	logic       framing_full_k;
	logic [1:0] bonding_mode;
	logic       rx_out_ready;
	logic       rx_out_valid_q;
	logic [9:0] rx_char_q;
	logic [2:0] rx_status_q;
	logic       rx_overrun_q;
	logic       recovered_clock_out_q;
	logic       serial_bit_in;
	logic       serial_bit_toggle;
	logic       tx_start;
	logic [63:0] tx_bits;
	logic [6:0] tx_count;
	logic       tx_busy;
	logic       clk_out_prev;
	logic [9:0] got_c [$];
	logic [2:0] got_s [$];
	int         n_mismatch;
	int         comparisons;
	int         n_ovr;
	int         n_rise;

	rx_decode_framer_select dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_bit_in(serial_bit_in),
		.serial_bit_toggle(serial_bit_toggle), .decoder_mode_select(decoder_mode_select),
		.reframe_mode_select(reframe_mode_select), .rx_clock_source_select(rx_clock_source_select),
		.rx_clock_rate_select(rx_clock_rate_select), .framing_full_k(framing_full_k), .bonding_mode(bonding_mode),
		.rx_out_ready(rx_out_ready), .rx_out_valid_q(rx_out_valid_q), .rx_char_q(rx_char_q),
		.rx_status_q(rx_status_q), .rx_overrun_q(rx_overrun_q), .recovered_clock_out_q(recovered_clock_out_q));
	serial_tx_model tx (.clk_sys(clk_sys), .tx_start(tx_start), .tx_bits(tx_bits), .tx_count(tx_count),
		.tx_busy(tx_busy), .serial_bit_in(serial_bit_in), .serial_bit_toggle(serial_bit_toggle));

	always #12.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		clk_out_prev <= recovered_clock_out_q;
		if (rst_n === 1'b1) begin
			if (rx_out_valid_q === 1'b1 && rx_out_ready === 1'b1) begin
				got_c.push_back(rx_char_q);
				got_s.push_back(rx_status_q);
			end
			if (rx_overrun_q === 1'b1) n_ovr++;
			if (recovered_clock_out_q === 1'b1 && clk_out_prev === 1'b0) n_rise++;
		end
	end

	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [9:0] has(input logic [9:0] v);
		foreach (got_c[i]) if (got_c[i] === v) return 10'h1;
		return 10'h0;
	endfunction

	task automatic run(input logic [1:0] dec, rf, src, bond, input logic fk, rdy,
		input logic [63:0] bits, input logic [6:0] cnt);
		@(negedge clk_sys);
		rst_n <= 1'b0;
		decoder_mode_select <= dec;
		reframe_mode_select <= rf;
		rx_clock_source_select <= src;
		bonding_mode <= bond;
		framing_full_k <= fk;
		rx_out_ready <= rdy;
		got_c.delete();
		got_s.delete();
		n_ovr = 0;
		n_rise = 0;
		repeat (12) @(negedge clk_sys);
		check("reset_valid", {9'h0, rx_out_valid_q}, 10'h0);
		rst_n <= 1'b1;
		repeat (12) @(negedge clk_sys);
		tx_bits <= bits;
		tx_count <= cnt;
		tx_start <= 1'b1;
		@(negedge clk_sys);
		tx_start <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 1000 && tx_busy; i++) @(posedge clk_sys);
		check("tx_finished", {9'h0, tx_busy}, 10'h0);
		repeat (20) @(posedge clk_sys);
	endtask

	task automatic final_report;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		final_report();
	end

	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		decoder_mode_select = 2'b00;
		reframe_mode_select = 2'b00;
		rx_clock_source_select = 2'b01;
		rx_clock_rate_select = 1'b0;
		framing_full_k = 1'b1;
		bonding_mode = 2'b00;
		rx_out_ready = 1'b1;
		tx_start = 1'b0;
		tx_bits = 64'h0;
		tx_count = 7'h0;
		n_mismatch = 0;
		comparisons = 0;
		foreach (rows[i]) begin
			run(rows[i].dec, rows[i].rf, 2'b01, 2'b00, rows[i].fk, 1'b1, {44'h0, K_CH, rows[i].data}, 7'd20);
			check("row_count", 10'(got_c.size()), 10'h2);
			check("row_first", got_c[0], rows[i].e0);
			check("row_second", got_c[1], rows[i].e1);
			if (rows[i].dec != 2'b00) check("row_st0", 10'(got_s[0]), 10'(rows[i].s0));
			if (rows[i].dec != 2'b00) check("row_st1", 10'(got_s[1]), 10'(rows[i].s1));
			check("row_clk_rises", 10'(n_rise), 10'h2);
		end
		run(2'b00, 2'b00, 2'b01, 2'b00, 1'b1, 1'b1, 64'({1'b1, K_CH, D_A, D_B}), 7'd31);
		check("low_garbage", got_c[0], 10'h27d);
		check("low_realign", got_c[1], K_CH);
		check("low_next", got_c[2], D_A);
		run(2'b00, 2'b01, 2'b01, 2'b00, 1'b1, 1'b1, 64'({1'b1, K_CH, D_A, D_B}), 7'd31);
		check("mid_one_match", has(D_A), 10'h0);
		run(2'b00, 2'b01, 2'b01, 2'b00, 1'b1, 1'b1, 64'({1'b1, K_CH, K_CH, D_A, D_B}), 7'd41);
		check("mid_two_match", has(D_A), 10'h1);
		check("mid_phase", 10'(got_c.size()), 10'h4);
		run(2'b00, 2'b11, 2'b01, 2'b00, 1'b1, 1'b1, 64'({1'b1, K_CH, K_CH, D_A, D_B}), 7'd41);
		check("high_two_match", has(D_A), 10'h0);
		run(2'b00, 2'b11, 2'b01, 2'b00, 1'b1, 1'b1, 64'({1'b1, K_CH, K_CH, K_CH, K_CH, D_A, D_B}), 7'd61);
		check("high_four_match", has(D_A), 10'h1);
		check("high_phase", 10'(got_c.size()), 10'h6);
		run(2'b00, 2'b00, 2'b01, 2'b01, 1'b1, 1'b1, 64'({1'b1, K_CH, D_A, D_B}), 7'd31);
		check("bonded_low", has(D_A), 10'h0);
		@(negedge clk_sys);
		rx_clock_rate_select <= 1'b1;
		run(2'b00, 2'b00, 2'b01, 2'b00, 1'b1, 1'b1, {44'h0, K_CH, D_A}, 7'd20);
		check("half_rate_rises", 10'(n_rise), 10'h1);
		check("half_rate_count", 10'(got_c.size()), 10'h2);
		@(negedge clk_sys);
		rx_clock_rate_select <= 1'b0;
		run(2'b01, 2'b01, 2'b00, 2'b00, 1'b1, 1'b0, 64'({K_CH, D_A, D_B}), 7'd30);
		check("stall_overrun", 10'(n_ovr), 10'h1);
		@(negedge clk_sys);
		rx_out_ready <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check("stall_count", 10'(got_c.size()), 10'h2);
		check("stall_first", got_c[0], 10'h0bc);
		check("stall_second", got_c[1], 10'h0b5);
		check("src_low_clk", 10'(n_rise), 10'h0);
		final_report();
	end
endmodule
